// [design/ldcb_bank.sv]
// per-unit configuration register bank behind the index/data ports
`timescale 1ns/1ps
module ldcb_bank import ldcb_pkg::*; #(
  parameter int UNITS = LDCB_UNITS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic standby_supply_powerup_reset_i,
  input wire logic host_bus_reset_i,
  input wire logic soft_reset_i,
  input wire logic config_state_i,
  input wire logic index_wr_i,
  input wire logic data_wr_i,
  input wire logic data_rd_i,
  input wire logic [7:0] wdata_i,
  input wire logic [UNITS-1:0] power_set_i,
  input wire logic [UNITS-1:0] power_clr_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic [UNITS-1:0] unit_active_o,
  output logic [UNITS-1:0] unit_decode_en_o,
  output logic [UNITS*8-1:0] unit_irq_sel_o,
  output logic [7:0] kbd_irq_sec_o,
  output logic [UNITS*32-1:0] unit_base_o
);
  // ==========================================================
  // elaboration check: tables in the package are sized for nine
  if (UNITS != LDCB_UNITS) begin : g_bad_units
    $error("ldcb_bank: UNITS must match the package tables");
  end

  localparam int DEPTH = UNITS * LDCB_BASE_REGS;
  localparam int AW = $clog2(DEPTH);

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] index;            // last value on the index port
    logic [7:0] unit;             // unit selector
    logic [UNITS-1:0] act;        // activate / power bits
    logic [UNITS-1:0][7:0] irq;   // primary irq select per unit
    logic [7:0] irq_sec;          // keyboard second irq select
    logic rd_pend;                // read waits for memory data
    logic [7:0] rd_idx;           // index of pending read
    logic [7:0] rd_unit;          // unit of pending read
    logic [7:0] rdata;            // read answer
    logic rvalid;                 // read answer strobe
    logic [UNITS-1:0] dec_en;     // unit may decode its ports
  } ldcb_state_s;
  ldcb_state_s st_reg;
  ldcb_state_s st_next;

  logic clr_all;            // any of the bank reset sources
  logic take_wr;            // data write accepted
  logic take_rd;            // data read accepted
  logic sel_ok;             // selector names an existing unit
  logic [3:0] uidx;         // selector clipped to array width
  logic base_hit;           // index in 0x60-0x63
  logic base_used;          // selected unit owns that base byte
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [AW-1:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic [DEPTH*8-1:0] mem_all;
  logic [UNITS-1:0] pri_ok;  // primary base within window
  logic rd_sel_ok;
  logic [3:0] rd_uidx;
  logic rd_used;

  // ==========================================================
  // access qualification
  always_comb begin
    // soft, standby and host bus resets all reload the bank
    clr_all = standby_supply_powerup_reset_i | host_bus_reset_i |
              soft_reset_i;
    take_wr = data_wr_i & config_state_i;
    take_rd = data_rd_i & config_state_i;
    sel_ok = 32'(st_reg.unit) < UNITS;
    uidx = sel_ok ? st_reg.unit[3:0] : 4'h0;
    base_hit = (st_reg.index >= IDX_PRI_BASE_HI) &&
               (st_reg.index <= IDX_SEC_BASE_LO);
    // low index bit picks high or low byte, bit 1 picks the pair
    base_used = sel_ok && (st_reg.index[1] ? UNIT_USES_SEC[uidx] :
                UNIT_USES_PRI[uidx]);
    mem_we = take_wr && base_hit && base_used;
    mem_waddr = AW'({uidx, st_reg.index[1:0]});
    mem_raddr = mem_waddr;
    rd_sel_ok = 32'(st_reg.rd_unit) < UNITS;
    rd_uidx = rd_sel_ok ? st_reg.rd_unit[3:0] : 4'h0;
    rd_used = rd_sel_ok && (st_reg.rd_idx[1] ?
              UNIT_USES_SEC[rd_uidx] : UNIT_USES_PRI[rd_uidx]);
  end

  // ==========================================================
  // base address store, registered read
  ldcb_base_mem #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(clr_all),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(wdata_i),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata),
    .all_o(mem_all)
  );

  // ==========================================================
  // window check of each unit's primary base
  genvar gi;
  generate
    for (gi = 0; gi < UNITS; gi++) begin : g_unit
      ldcb_range_chk u_chk (
        .base_i({mem_all[(gi*4)*8 +: 8], mem_all[(gi*4+1)*8 +: 8]}),
        .max_i(UNIT_BASE_MAX[gi]),
        .align_i(UNIT_ALIGN[gi]),
        .ok_o(pri_ok[gi])
      );
      assign unit_irq_sel_o[gi*8 +: 8] = st_reg.irq[gi];
    end
  endgenerate

  // ==========================================================
  // next state
  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    st_next.rd_pend = take_rd;
    if (config_state_i && index_wr_i) begin
      st_next.index = wdata_i;
    end
    // register writes through the data port
    if (take_wr) begin
      unique case (st_reg.index)
        IDX_UNIT_SEL: begin
          st_next.unit = wdata_i;
        end
        IDX_ACTIVATE: begin
          // upper bits are reserved and simply not stored
          if (sel_ok) begin
            st_next.act[uidx] = wdata_i[ACT_BIT];
          end
        end
        IDX_PRI_IRQ: begin
          if (sel_ok) begin
            st_next.irq[uidx] = wdata_i;
          end
        end
        IDX_SEC_IRQ: begin
          if (st_reg.unit == LDCB_KBD_UNIT) begin
            st_next.irq_sec = wdata_i;
          end
        end
        // reserved, unused and unimplemented indexes drop writes
        default: begin
        end
      endcase
    end
    // power bit and activate bit are one flop, so either sets both
    st_next.act = (st_next.act & ~power_clr_i) | power_set_i;
    // read capture; the memory answers one cycle later
    if (take_rd) begin
      st_next.rd_idx = st_reg.index;
      st_next.rd_unit = st_reg.unit;
    end
    if (st_reg.rd_pend) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = BYTE_ZERO;
      if (st_reg.rd_idx == IDX_UNIT_SEL) begin
        st_next.rdata = st_reg.rd_unit;
      end else if (rd_sel_ok) begin
        if (st_reg.rd_idx == IDX_ACTIVATE) begin
          st_next.rdata[ACT_BIT] = st_reg.act[rd_uidx];
        end else if ((st_reg.rd_idx >= IDX_PRI_BASE_HI) &&
                     (st_reg.rd_idx <= IDX_SEC_BASE_LO) && rd_used) begin
          st_next.rdata = mem_rdata;
        end else if (st_reg.rd_idx == IDX_PRI_IRQ) begin
          st_next.rdata = st_reg.irq[rd_uidx];
        end else if (st_reg.rd_idx == IDX_SEC_IRQ &&
                     st_reg.rd_unit == LDCB_KBD_UNIT) begin
          st_next.rdata = st_reg.irq_sec;
        end
      end
    end
    // a unit without a relocatable base decodes on activate alone
    st_next.dec_en = st_reg.act & (~UNIT_USES_PRI | pri_ok);
    // bank reset sources; the selector survives a soft reset
    if (clr_all) begin
      st_next.act = '0;
      st_next.irq = '0;
      // zero select code means edge triggered, active high
      st_next.irq[0] = U0_PRI_IRQ_RST;
      st_next.irq_sec = BYTE_ZERO;
      if (host_bus_reset_i) begin
        st_next.unit = BYTE_ZERO;
        st_next.index = BYTE_ZERO;
      end
    end
  end

  // ==========================================================
  // register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.irq[0] <= U0_PRI_IRQ_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs, all from flops
  always_comb begin
    rdata_o = st_reg.rdata;
    rvalid_o = st_reg.rvalid;
    unit_active_o = st_reg.act;
    unit_decode_en_o = st_reg.dec_en;
    kbd_irq_sec_o = st_reg.irq_sec;
    unit_base_o = mem_all;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic [7:0] past_unit;
  logic past_any_pwr;
  logic [AW-1:0] past_waddr; // base byte address of last cycle
  always_ff @(posedge clk_i) begin
    past_unit <= st_reg.unit;
    past_waddr <= mem_waddr;
    past_any_pwr <= (|power_set_i) | (|power_clr_i) | clr_all;
  end

  sel_write_a: assert property (
    take_wr && st_reg.index == IDX_UNIT_SEL && !host_bus_reset_i
    |=> st_reg.unit == $past(wdata_i))
    else $error("unit selector not loaded");

  read_lat_a: assert property (
    take_rd |-> ##2 rvalid_o)
    else $error("read answer not two cycles after request");

  cfg_gate_a: assert property (
    data_rd_i && !config_state_i |-> ##2 !rvalid_o)
    else $error("read answered outside configuration state");

  act_write_a: assert property (
    take_wr && st_reg.index == IDX_ACTIVATE && sel_ok
    ##1 !past_any_pwr
    |-> unit_active_o[past_unit[3:0]] == $past(wdata_i[0]))
    else $error("activate bit not written");

  resv_read_a: assert property (
    take_rd && st_reg.index >= IDX_CTRL_LO &&
    st_reg.index <= IDX_MEMBASE_HI |-> ##2 rdata_o == BYTE_ZERO)
    else $error("reserved index read nonzero");

  base_gap_a: assert property (
    take_rd && st_reg.index > IDX_SEC_BASE_LO &&
    st_reg.index <= IDX_BASE_END |-> ##2 rdata_o == BYTE_ZERO)
    else $error("unused base index read nonzero");

  kbd_only_a: assert property (
    take_rd && st_reg.index == IDX_SEC_IRQ &&
    st_reg.unit != LDCB_KBD_UNIT |-> ##2 rdata_o == BYTE_ZERO)
    else $error("second irq select seen outside keyboard unit");

  gap_read_a: assert property (
    take_rd && (st_reg.index == IDX_GAP_A ||
    st_reg.index == IDX_GAP_B) |-> ##2 rdata_o == BYTE_ZERO)
    else $error("unimplemented index read nonzero");

  pwr_link_a: assert property (
    power_set_i[0] && !clr_all
    |=> unit_active_o[0] ##1 unit_decode_en_o[0] ||
    !pri_ok[0] || $past(power_clr_i[0]) || $past(clr_all))
    else $error("power bit did not activate unit");

  dec_gate_a: assert property (
    unit_decode_en_o[0] |-> $past(unit_active_o[0]) &&
    $past(pri_ok[0]))
    else $error("unit decodes with bad base or inactive");

  soft_rst_a: assert property (
    soft_reset_i |=> unit_irq_sel_o[7:0] == U0_PRI_IRQ_RST &&
    kbd_irq_sec_o == BYTE_ZERO && unit_active_o == '0)
    else $error("soft reset defaults wrong");

  base_wr_a: assert property (
    mem_we && !clr_all
    |=> mem_all[past_waddr*8 +: 8] == $past(wdata_i))
    else $error("base byte write did not land");

  irq_wr_a: assert property (
    take_wr && st_reg.index == IDX_PRI_IRQ && sel_ok && !clr_all
    |=> unit_irq_sel_o[past_unit[3:0]*8 +: 8] == $past(wdata_i))
    else $error("primary irq select not written");

  sec_keep_a: assert property (
    take_wr && st_reg.index == IDX_SEC_IRQ &&
    st_reg.unit != LDCB_KBD_UNIT && !clr_all |=> $stable(kbd_irq_sec_o))
    else $error("second irq select written outside keyboard unit");

  bank_clr_a: assert property (
    clr_all |=> mem_all[DEPTH*8-1:16] == '0 &&
    mem_all[15:0] == {U0_BASE_LO_RST, U0_BASE_HI_RST})
    else $error("bank reset left a base byte set");

  resv_wr_a: assert property (
    take_wr && st_reg.index >= IDX_CTRL_LO &&
    st_reg.index <= IDX_MEMBASE_HI && !clr_all &&
    !(|power_set_i) && !(|power_clr_i) |=>
    $stable(unit_active_o) && $stable(unit_irq_sel_o) &&
    $stable(kbd_irq_sec_o) && $stable(mem_all))
    else $error("reserved index write changed a register");

  rd_cov_c: cover property (take_rd ##2 rvalid_o);
  sel_cov_c: cover property (
    take_wr && st_reg.index == IDX_UNIT_SEL ##1 take_rd);
  dec_cov_c: cover property (unit_decode_en_o[3]);
  pwr_cov_c: cover property (power_set_i[0] ##2 unit_decode_en_o[0]);
endmodule

// [design/ldcb_base_mem.sv]
// base address byte store: one entry per unit and base byte
`timescale 1ns/1ps
module ldcb_base_mem import ldcb_pkg::*; #(
  parameter int DEPTH = LDCB_UNITS * LDCB_BASE_REGS,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [7:0] rdata_o,
  output logic [DEPTH*8-1:0] all_o
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem; // stored base bytes
    logic [7:0] rd;             // registered read data
  } ldcb_mem_s;
  ldcb_mem_s st_reg;
  ldcb_mem_s st_next;

  // ==========================================================
  // next state: clear to defaults, else one write
  always_comb begin
    st_next = st_reg;
    st_next.rd = st_reg.mem[raddr_i];
    if (clr_i) begin
      // every reset source clears the bases; unit 0 has its own pair
      st_next.mem = '0;
      st_next.mem[0] = U0_BASE_HI_RST;
      st_next.mem[1] = U0_BASE_LO_RST;
    end else if (we_i && (32'(waddr_i) < DEPTH)) begin
      st_next.mem[waddr_i] = wdata_i;
    end
  end

  // ==========================================================
  // register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.mem[0] <= U0_BASE_HI_RST;
      st_reg.mem[1] <= U0_BASE_LO_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_o = st_reg.rd;
  assign all_o = st_reg.mem;
endmodule

// [design/ldcb_pkg.sv]
// package: constants of the per-unit configuration register bank
package ldcb_pkg;
  // ==========================================================
  // bank geometry
  localparam int LDCB_UNITS = 9;
  localparam int LDCB_BASE_REGS = 4;
  localparam logic [7:0] LDCB_KBD_UNIT = 8'h07;
  // ==========================================================
  // index map (values seen on the index port)
  localparam logic [7:0] IDX_UNIT_SEL = 8'h07;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_CTRL_LO = 8'h31;
  localparam logic [7:0] IDX_MEMBASE_HI = 8'h5F;
  localparam logic [7:0] IDX_PRI_BASE_HI = 8'h60;
  localparam logic [7:0] IDX_PRI_BASE_LO = 8'h61;
  localparam logic [7:0] IDX_SEC_BASE_HI = 8'h62;
  localparam logic [7:0] IDX_SEC_BASE_LO = 8'h63;
  localparam logic [7:0] IDX_BASE_END = 8'h6F;
  localparam logic [7:0] IDX_PRI_IRQ = 8'h70;
  localparam logic [7:0] IDX_GAP_A = 8'h71;
  localparam logic [7:0] IDX_SEC_IRQ = 8'h72;
  localparam logic [7:0] IDX_GAP_B = 8'h73;
  // ==========================================================
  // field positions and reset values
  localparam int ACT_BIT = 0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] U0_PRI_IRQ_RST = 8'h06;
  localparam logic [7:0] U0_BASE_HI_RST = 8'h03;
  localparam logic [7:0] U0_BASE_LO_RST = 8'hF0;
  // ==========================================================
  // per-unit base address usage and legal window
  localparam logic [8:0] UNIT_USES_PRI = 9'h179;
  localparam logic [8:0] UNIT_USES_SEC = 9'h040;
  localparam logic [15:0] BASE_MIN = 16'h0100;
  localparam logic [15:0] UNIT_BASE_MAX [LDCB_UNITS] = '{
    16'h0FF8, 16'h0FF8, 16'h0FF8, 16'h0FFC, 16'h0FF8,
    16'h0FF8, 16'h0FFE, 16'h0FF8, 16'h0FF8};
  localparam logic [15:0] UNIT_ALIGN [LDCB_UNITS] = '{
    16'h0007, 16'h0007, 16'h0007, 16'h0003, 16'h0007,
    16'h0007, 16'h0001, 16'h0007, 16'h0007};
endpackage

// [design/ldcb_range_chk.sv]
// checks one base address against a unit's legal window
`timescale 1ns/1ps
module ldcb_range_chk import ldcb_pkg::*; (
  input wire logic [15:0] base_i,
  input wire logic [15:0] max_i,
  input wire logic [15:0] align_i,
  output logic ok_o
);
  // ==========================================================
  // inside [min, max] and on the unit's boundary
  always_comb begin
    ok_o = (base_i >= BASE_MIN) && (base_i <= max_i) &&
           ((base_i & align_i) == 16'h0000);
  end
endmodule

// [testbench/ldcb_host_model.sv]
// host model: index/data port cycles into the configuration bank
`timescale 1ns/1ps
module ldcb_host_model import ldcb_pkg::*; (
  input wire logic clk_i,
  input wire logic rvalid_i,
  input wire logic [7:0] rdata_i,
  output logic config_state_o,
  output logic index_wr_o,
  output logic data_wr_o,
  output logic data_rd_o,
  output logic [7:0] wdata_o
);
  // ==========================================================
  // idle bus state
  initial begin
    config_state_o = 1'b1;
    {index_wr_o, data_wr_o, data_rd_o} = 3'h0;
    wdata_o = 8'hA5;
  end
  // ==========================================================
  // one strobe for one cycle; data then scrambled, so no stale byte
  task automatic pulse(input logic [1:0] kind, input logic [7:0] d);
    @(negedge clk_i);
    wdata_o = d;
    index_wr_o = (kind == 2'h0);
    data_wr_o = (kind == 2'h1);
    data_rd_o = (kind == 2'h2);
    @(negedge clk_i);
    {index_wr_o, data_wr_o, data_rd_o} = 3'h0;
    wdata_o = ~d;
  endtask
  // enter or leave the configuration state between cycles
  task automatic set_cfg(input logic b);
    config_state_o = b;
  endtask
  // index port first, then data port
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    pulse(2'h0, idx);
    pulse(2'h1, d);
  endtask
  // reserved upper bits always sent as zero
  task automatic wr_act(input logic b);
    wr(IDX_ACTIVATE, {7'h00, b});
  endtask
  // read: answer looked for in a short bounded window
  task automatic rd(input logic [7:0] idx, output logic [7:0] d,
                    output logic ok);
    pulse(2'h0, idx);
    pulse(2'h2, 8'h00);
    ok = 1'b0;
    d = 8'h00;
    repeat (3) begin
      if (!ok && rvalid_i === 1'b1) begin
        ok = 1'b1;
        d = rdata_i;
      end
      @(negedge clk_i);
    end
  endtask
endmodule

// [testbench/test_logical_device_config_bank.sv]
// testbench: per-unit configuration bank scenarios
`timescale 1ns/1ps
module test_logical_device_config_bank import ldcb_pkg::*;;
  // ==========================================================
  // signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] rst3 = 3'h0; // standby, host bus, soft resets
  logic [8:0] pset = 9'h000, pclr = 9'h000;
  logic cfg, iwr, dwr, drd, rvalid;
  logic [7:0] wdata, rdata, ksec;
  logic [8:0] act, dec;
  logic [71:0] irq;
  logic [287:0] base;
  int err_count = 0;
  int checked = 0;
  // ==========================================================
  // design and host model
  ldcb_bank dut (.clk_i(clk_i), .rst_i(rst_i),
    .standby_supply_powerup_reset_i(rst3[0]),
    .host_bus_reset_i(rst3[1]), .soft_reset_i(rst3[2]),
    .config_state_i(cfg), .index_wr_i(iwr), .data_wr_i(dwr),
    .data_rd_i(drd), .wdata_i(wdata), .power_set_i(pset),
    .power_clr_i(pclr), .rdata_o(rdata), .rvalid_o(rvalid),
    .unit_active_o(act), .unit_decode_en_o(dec),
    .unit_irq_sel_o(irq), .kbd_irq_sec_o(ksec), .unit_base_o(base));
  ldcb_host_model host (.clk_i(clk_i), .rvalid_i(rvalid),
    .rdata_i(rdata), .config_state_o(cfg), .index_wr_o(iwr),
    .data_wr_o(dwr), .data_rd_o(drd), .wdata_o(wdata));
  // ==========================================================
  // helpers
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // read a register and compare it; a missing answer also counts
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.rd(idx, d, ok);
    chk({15'h0, ok}, 16'h0001);
    chk({8'h00, d}, {8'h00, exp});
  endtask
  task automatic sel(input logic [7:0] u);
    host.wr(IDX_UNIT_SEL, u);
  endtask
  task automatic settle();
    repeat (2) @(negedge clk_i);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    sel(8'h00);
    rchk(IDX_PRI_BASE_HI, 8'h03);
    rchk(IDX_PRI_BASE_LO, 8'hF0);
    rchk(IDX_PRI_IRQ, 8'h06);
    rchk(IDX_ACTIVATE, 8'h00);
    sel(8'h07);
    rchk(IDX_SEC_IRQ, 8'h00);
    sel(8'h05);
    rchk(IDX_PRI_BASE_HI, 8'h00);
    rchk(IDX_PRI_IRQ, 8'h00);
  endtask
  task automatic t_activate();
    sel(8'h03);
    host.wr_act(1'b1);
    settle();
    chk({7'h0, act}, 16'h0008);
    rchk(IDX_ACTIVATE, 8'h01);
    host.wr_act(1'b0);
    settle();
    chk({15'h0, act[3]}, 16'h0000);
  endtask
  // reserved and unused places on a unit that has one base pair
  task automatic t_reserved();
    logic [7:0] lst [12] = '{8'h31, 8'h37, 8'h38, 8'h3F, 8'h40,
      8'h5F, 8'h62, 8'h63, 8'h6F, 8'h71, 8'h72, 8'h73};
    sel(8'h03);
    foreach (lst[i]) begin
      host.wr(lst[i], 8'hFF);
      rchk(lst[i], 8'h00);
    end
    sel(8'h07);
    host.wr(IDX_SEC_IRQ, 8'h0B);
    rchk(IDX_SEC_IRQ, 8'h0B);
    chk({8'h00, ksec}, 16'h000B);
    sel(8'h01);
    host.wr(IDX_PRI_IRQ, 8'h05);
    rchk(IDX_PRI_IRQ, 8'h05);
    chk({8'h00, irq[15:8]}, 16'h0005);
  endtask
  task automatic t_base();
    sel(8'h06);
    host.wr(IDX_PRI_BASE_HI, 8'h01);
    host.wr(IDX_PRI_BASE_LO, 8'h70);
    host.wr(IDX_SEC_BASE_HI, 8'h02);
    host.wr(IDX_SEC_BASE_LO, 8'h40);
    rchk(IDX_SEC_BASE_HI, 8'h02);
    rchk(IDX_SEC_BASE_LO, 8'h40);
    chk(base[6*32 +: 16], 16'h7001);
    chk(base[6*32+16 +: 16], 16'h4002);
  endtask
  task automatic t_decode();
    sel(8'h03);
    host.wr(IDX_PRI_BASE_HI, 8'h03);
    host.wr(IDX_PRI_BASE_LO, 8'h78);
    host.wr_act(1'b1);
    settle();
    chk({15'h0, dec[3]}, 16'h0001);
    host.wr(IDX_PRI_BASE_LO, 8'h7A);
    settle();
    chk({15'h0, dec[3]}, 16'h0000);
    sel(8'h04);
    rchk(IDX_PRI_BASE_HI, 8'h00);
  endtask
  // outside the configuration state nothing is taken or answered
  task automatic t_cfg();
    logic [7:0] d;
    logic ok;
    sel(8'h03);
    host.set_cfg(1'b0);
    host.wr(IDX_PRI_BASE_LO, 8'h55);
    host.rd(IDX_PRI_BASE_LO, d, ok);
    chk({15'h0, ok}, 16'h0000);
    host.set_cfg(1'b1);
    rchk(IDX_PRI_BASE_LO, 8'h7A);
  endtask
  // each of the three extra resets reloads the bank defaults
  task automatic t_resets();
    for (int r = 0; r < 3; r++) begin
      sel(8'h03);
      host.wr(IDX_PRI_BASE_LO, 8'h78);
      host.wr_act(1'b1);
      @(negedge clk_i);
      rst3[r] = 1'b1;
      @(negedge clk_i);
      rst3[r] = 1'b0;
      settle();
      chk({7'h0, act}, 16'h0000);
      chk(base[3*32 +: 16], 16'h0000);
      chk(base[0 +: 16], 16'hF003);
    end
  endtask
  task automatic t_power();
    pset[5] = 1'b1;
    @(negedge clk_i);
    pset[5] = 1'b0;
    settle();
    chk({15'h0, act[5]}, 16'h0001);
    sel(8'h05);
    rchk(IDX_ACTIVATE, 8'h01);
    pclr[5] = 1'b1;
    @(negedge clk_i);
    pclr[5] = 1'b0;
    settle();
    rchk(IDX_ACTIVATE, 8'h00);
    // unit 0 keeps its legal default base, so power alone decodes
    pset[0] = 1'b1;
    @(negedge clk_i);
    pset[0] = 1'b0;
    settle();
    chk({15'h0, dec[0]}, 16'h0001);
    pclr[0] = 1'b1;
    @(negedge clk_i);
    pclr[0] = 1'b0;
    settle();
    chk({15'h0, act[0]}, 16'h0000);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    t_reset();
    t_activate();
    t_reserved();
    t_base();
    t_decode();
    t_cfg();
    t_resets();
    t_power();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    tally_and_finish();
  end
endmodule
